// ===== rtl/tc16_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tc16_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // CPU byte access
  input wire tc16_pkg::tc16_io_req_t io_req,
  output logic [7:0] io_rdata,
  // Interrupt side: index 0 overflow, 1 compare a, 2 compare b, 3 capture
  input wire logic global_int_en,
  input wire logic [3:0] vector_taken,
  output logic [3:0] irq_req,
  // Pins
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic external_clock_pin,
  output logic waveform_output_a,
  output logic waveform_output_b
);
  logic [7:0] ctrl_a_q, ctrl_b_q, temp_q, rdata_q, rd_d;
  logic [15:0] cnt_q, cap_q, top;
  logic [1:0][15:0] cmp_q;
  logic [9:0] pres_q;
  logic [3:0] flags_q, en_q, irq_q, fset, fclr, wr_bits;
  logic [1:0] wave_q, match, force_s;
  logic ext_q, src_prev_q, dn_q, block_q, tick, src, cap_trig, tov;
  logic cnt_wr, cap_wr, phase, fast, pwm, icr_top, at_top;
  logic [3:0] wgm;
  tc16_pkg::tc16_cs_t cs;

  function automatic logic [7:0] pack4(input logic [3:0] v);
    pack4 = 8'h00;
    pack4[tc16_pkg::B_OVF] = v[0];
    pack4[tc16_pkg::B_CMPA] = v[1];
    pack4[tc16_pkg::B_CMPB] = v[2];
    pack4[tc16_pkg::B_CAP] = v[3];
  endfunction

  assign wr_bits = {io_req.wdata[tc16_pkg::B_CAP], io_req.wdata[tc16_pkg::B_CMPB],
                    io_req.wdata[tc16_pkg::B_CMPA], io_req.wdata[tc16_pkg::B_OVF]};
  assign cnt_wr = io_req.wr && io_req.addr == tc16_pkg::A_CNT_L;
  assign cap_wr = io_req.wr && io_req.addr == tc16_pkg::A_CAP_L;
  assign wgm = {ctrl_b_q[tc16_pkg::B_WGM_HI -: 2], ctrl_a_q[tc16_pkg::B_WGM_LO +: 2]};
  assign phase = tc16_pkg::PHASE_MODES[wgm];
  assign fast = tc16_pkg::FAST_MODES[wgm];
  assign pwm = phase | fast;
  assign icr_top = tc16_pkg::ICR_TOP_MODES[wgm];
  assign cs = tc16_pkg::tc16_cs_t'(ctrl_b_q[tc16_pkg::B_CS +: 3]);
  assign at_top = cnt_q == top;

  always_comb begin
    if (icr_top) begin
      top = cap_q;
    end else if (tc16_pkg::OCRA_TOP_MODES[wgm]) begin
      top = cmp_q[0];
    end else begin
      unique case (wgm[1:0])
        2'h1: top = tc16_pkg::TOP_8;
        2'h2: top = tc16_pkg::TOP_9;
        2'h3: top = tc16_pkg::TOP_10;
        default: top = tc16_pkg::TOP_MAX;
      endcase
    end
  end

  // Prescaler runs free so a divided clock keeps its phase across selects
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pres_q <= 10'h000;
    end else begin
      pres_q <= pres_q + 10'h001;
    end
  end

  // Pin level read regardless of its port direction
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= external_clock_pin;
    end
  end

  always_comb begin
    unique case (cs)
      tc16_pkg::CS_STOP: tick = 1'b0;
      tc16_pkg::CS_DIV1: tick = 1'b1;
      tc16_pkg::CS_DIV8: tick = &pres_q[2:0];
      tc16_pkg::CS_DIV64: tick = &pres_q[5:0];
      tc16_pkg::CS_DIV256: tick = &pres_q[7:0];
      tc16_pkg::CS_DIV1024: tick = &pres_q;
      tc16_pkg::CS_EXT_FALL: tick = ext_q & ~external_clock_pin;
      tc16_pkg::CS_EXT_RISE: tick = ~ext_q & external_clock_pin;
    endcase
  end

  // Counter: a CPU write beats a timer clock in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= tc16_pkg::WORD_RST;
      dn_q <= 1'b0;
    end else if (cnt_wr) begin
      cnt_q <= {temp_q, io_req.wdata};
    end else if (tick && phase) begin
      if (!dn_q && at_top) begin
        dn_q <= 1'b1;
        cnt_q <= cnt_q - 16'h0001;
      end else if (dn_q && cnt_q == tc16_pkg::WORD_RST) begin
        dn_q <= 1'b0;
        cnt_q <= cnt_q + 16'h0001;
      end else begin
        cnt_q <= dn_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      end
    end else if (tick) begin
      dn_q <= 1'b0;
      cnt_q <= at_top ? tc16_pkg::WORD_RST : cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      block_q <= 1'b0;
    end else if (cnt_wr) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  always_comb begin
    if (phase) begin
      tov = tick && dn_q && cnt_q == tc16_pkg::WORD_RST;
    end else if (fast) begin
      tov = tick && at_top;
    end else begin
      tov = tick && cnt_q == tc16_pkg::TOP_MAX;
    end
  end

  // Capture
  assign src = ctrl_a_q[tc16_pkg::B_CAPSRC] ? comparator_out : capture_input_pin;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src;
    end
  end
  assign cap_trig = !icr_top && (ctrl_b_q[tc16_pkg::B_ICES] ? src && !src_prev_q : !src && src_prev_q);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cap_q <= tc16_pkg::WORD_RST;
    end else if (cap_wr) begin
      cap_q <= {temp_q, io_req.wdata};
    end else if (cap_trig) begin
      cap_q <= cnt_q;
    end
  end

  // Compare channels, index 0 is channel a
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    localparam logic [7:0] LO = (ch == 0) ? tc16_pkg::A_CMPA_L : tc16_pkg::A_CMPB_L;
    logic [1:0] com;
    assign com = ctrl_a_q[tc16_pkg::B_COMA - 2 * ch -: 2];
    assign match[ch] = tick && !block_q && cnt_q == cmp_q[ch];
    assign force_s[ch] = io_req.wr && io_req.addr == tc16_pkg::A_CTRL_C
                         && io_req.wdata[tc16_pkg::B_FOCA - ch] && !pwm;
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        cmp_q[ch] <= tc16_pkg::WORD_RST;
      end else if (io_req.wr && io_req.addr == LO) begin
        cmp_q[ch] <= {temp_q, io_req.wdata};
      end
    end
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        wave_q[ch] <= 1'b0;
      end else if (!pwm) begin
        if (match[ch] || force_s[ch]) begin
          unique case (com)
            2'h0: wave_q[ch] <= wave_q[ch];
            2'h1: wave_q[ch] <= ~wave_q[ch];
            2'h2: wave_q[ch] <= 1'b0;
            2'h3: wave_q[ch] <= 1'b1;
          endcase
        end
      end else if (com == 2'h1) begin
        if (match[ch] && ch == 0 && tc16_pkg::TOGGLE_PWM_MODES[wgm]) begin
          wave_q[ch] <= ~wave_q[ch];
        end
      end else if (com[1]) begin
        // Top action wins when compare equals top
        if (fast && tick && at_top) begin
          wave_q[ch] <= ~com[0];
        end else if (match[ch]) begin
          wave_q[ch] <= (phase && dn_q) ? ~com[0] : com[0];
        end
      end
    end
  end

  // Flags: force never sets one; a set beats a clear in the same cycle
  assign fset = {cap_trig || (tick && at_top && icr_top), match[1], match[0], tov};
  assign fclr = ((io_req.wr && io_req.addr == tc16_pkg::A_FLAGS) ? wr_bits : 4'h0) | vector_taken;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= (flags_q & ~fclr) | fset;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      en_q <= 4'h0;
    end else if (io_req.wr && io_req.addr == tc16_pkg::A_MASK) begin
      en_q <= wr_bits;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_q <= 4'h0;
    end else begin
      irq_q <= flags_q & en_q & {4{global_int_en}};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_a_q <= tc16_pkg::CTRL_RST;
    end else if (io_req.wr && io_req.addr == tc16_pkg::A_CTRL_A) begin
      ctrl_a_q <= io_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_b_q <= tc16_pkg::CTRL_RST;
    end else if (io_req.wr && io_req.addr == tc16_pkg::A_CTRL_B) begin
      ctrl_b_q <= io_req.wdata;
      ctrl_b_q[tc16_pkg::B_RSV] <= 1'b0;
    end
  end

  // Shared high byte: loaded by high writes and by counter and capture low reads
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      temp_q <= 8'h00;
    end else if (io_req.wr && io_req.addr inside {tc16_pkg::A_CNT_H, tc16_pkg::A_CAP_H,
                                                 tc16_pkg::A_CMPA_H, tc16_pkg::A_CMPB_H}) begin
      temp_q <= io_req.wdata;
    end else if (io_req.rd && io_req.addr == tc16_pkg::A_CNT_L) begin
      temp_q <= cnt_q[15:8];
    end else if (io_req.rd && io_req.addr == tc16_pkg::A_CAP_L) begin
      temp_q <= cap_q[15:8];
    end
  end

  always_comb begin
    unique case (io_req.addr)
      tc16_pkg::A_CTRL_A: rd_d = ctrl_a_q;
      tc16_pkg::A_CTRL_B: rd_d = ctrl_b_q;
      tc16_pkg::A_CNT_L: rd_d = cnt_q[7:0];
      tc16_pkg::A_CAP_L: rd_d = cap_q[7:0];
      tc16_pkg::A_CNT_H, tc16_pkg::A_CAP_H: rd_d = temp_q;
      tc16_pkg::A_CMPA_L: rd_d = cmp_q[0][7:0];
      tc16_pkg::A_CMPA_H: rd_d = cmp_q[0][15:8];
      tc16_pkg::A_CMPB_L: rd_d = cmp_q[1][7:0];
      tc16_pkg::A_CMPB_H: rd_d = cmp_q[1][15:8];
      tc16_pkg::A_MASK: rd_d = pack4(en_q);
      tc16_pkg::A_FLAGS: rd_d = pack4(flags_q);
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= io_req.rd ? rd_d : 8'h00;
    end
  end

  assign io_rdata = rdata_q;
  assign irq_req = irq_q;
  assign waveform_output_a = wave_q[0];
  assign waveform_output_b = wave_q[1];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_edge;
    (!icr_top && ctrl_b_q[tc16_pkg::B_ICES] && src && !src_prev_q) |-> cap_trig;
  endproperty
  a_edge: assert property (p_edge) else $error("rising edge missed");
  property p_cap;
    (cap_trig && !cap_wr) |=> cap_q == $past(cnt_q) && flags_q[3];
  endproperty
  a_cap: assert property (p_cap) else $error("capture not taken");
  property p_icr_top;
    (icr_top && !cap_wr) |=> $stable(cap_q);
  endproperty
  a_icr_top: assert property (p_icr_top) else $error("capture while top");
  property p_stop;
    (cs == tc16_pkg::CS_STOP && !cnt_wr) |=> $stable(cnt_q);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");
  property p_ext;
    (cs == tc16_pkg::CS_EXT_RISE && !cnt_wr && !phase && !at_top && !ext_q && external_clock_pin)
      |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_ext: assert property (p_ext) else $error("pin edge not counted");
  property p_force;
    (force_s[0] && ctrl_a_q[tc16_pkg::B_COMA -: 2] == 2'h3 && !flags_q[1] && !match[0])
      |=> waveform_output_a && !flags_q[1];
  endproperty
  a_force: assert property (p_force) else $error("force misbehaved");
  property p_foc_rd;
    (io_req.rd && io_req.addr == tc16_pkg::A_CTRL_C) |=> io_rdata == 8'h00;
  endproperty
  a_foc_rd: assert property (p_foc_rd) else $error("force bits read nonzero");
  property p_word;
    (io_req.wr && io_req.addr == tc16_pkg::A_CNT_H) ##1 !io_req.wr ##1 cnt_wr
      |=> cnt_q == {$past(io_req.wdata, 3), $past(io_req.wdata)};
  endproperty
  a_word: assert property (p_word) else $error("counter word torn");
  property p_block;
    cnt_wr |=> !match[0] && !match[1];
  endproperty
  a_block: assert property (p_block) else $error("match after counter write");
  property p_cmp;
    (match != 2'b00) |=> (flags_q[2:1] & $past(match)) == $past(match);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag late");
  property p_irq;
    global_int_en |=> irq_req == ($past(flags_q) & $past(en_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  property p_tov;
    (tick && !phase && !fast && cnt_q == tc16_pkg::TOP_MAX) |=> flags_q[0];
  endproperty
  a_tov: assert property (p_tov) else $error("overflow flag missed");
  property p_icf_top;
    (tick && icr_top && at_top) |=> flags_q[3];
  endproperty
  a_icf_top: assert property (p_icf_top) else $error("top capture flag missed");
  property p_clr;
    (vector_taken != 4'h0) |=> (flags_q & $past(vector_taken & ~fset)) == 4'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_rsv;
    (io_req.rd && io_req.addr == tc16_pkg::A_MASK) |=> (io_rdata & tc16_pkg::RSV_MASK) == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
  property p_wr0;
    (io_req.wr && io_req.addr == tc16_pkg::A_FLAGS && io_req.wdata == 8'h00 && vector_taken == 4'h0)
      |=> (flags_q & $past(flags_q)) == $past(flags_q);
  endproperty
  a_wr0: assert property (p_wr0) else $error("zero write cleared flag");
  c_cap: cover property (cap_trig);
  c_force: cover property (force_s[1]);
  c_tov_phase: cover property (phase && tov);
  c_ext: cover property (cs == tc16_pkg::CS_EXT_FALL && tick);
endmodule
`default_nettype wire

// ===== rtl/tc16_pkg.sv
package tc16_pkg;
  // Byte locations on the CPU I/O port
  localparam logic [7:0] A_CTRL_A = 8'h00;
  localparam logic [7:0] A_CTRL_B = 8'h01;
  localparam logic [7:0] A_CTRL_C = 8'h02;
  localparam logic [7:0] A_CNT_L = 8'h04;
  localparam logic [7:0] A_CNT_H = 8'h05;
  localparam logic [7:0] A_CAP_L = 8'h06;
  localparam logic [7:0] A_CAP_H = 8'h07;
  localparam logic [7:0] A_CMPA_L = 8'h08;
  localparam logic [7:0] A_CMPA_H = 8'h09;
  localparam logic [7:0] A_CMPB_L = 8'h0a;
  localparam logic [7:0] A_CMPB_H = 8'h0b;
  localparam logic [7:0] A_MASK = 8'h0c;
  localparam logic [7:0] A_FLAGS = 8'h0d;
  // Field positions
  localparam int B_ICES = 6;
  localparam int B_RSV = 5;
  localparam int B_WGM_HI = 4;
  localparam int B_WGM_LO = 0;
  localparam int B_CS = 0;
  localparam int B_COMA = 7;
  localparam int B_CAPSRC = 2;
  localparam int B_FOCA = 7;
  localparam int B_CAP = 5;
  localparam int B_CMPB = 2;
  localparam int B_CMPA = 1;
  localparam int B_OVF = 0;
  localparam logic [7:0] RSV_MASK = 8'hd8;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // Fixed tops
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  // Mode sets, one bit per waveform mode number
  localparam logic [15:0] PHASE_MODES = 16'h0f0e;
  localparam logic [15:0] FAST_MODES = 16'hc0e0;
  localparam logic [15:0] ICR_TOP_MODES = 16'h5500;
  localparam logic [15:0] OCRA_TOP_MODES = 16'h8a10;
  localparam logic [15:0] TOGGLE_PWM_MODES = 16'hcf00;
  typedef enum logic [2:0] {
    CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
  } tc16_cs_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tc16_io_req_t;
endpackage

// ===== tb/tc16_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tc16_pin_model (
  // Clock
  input wire logic sys_clk,
  // Far-side pins
  output logic capture_input_pin,
  output logic comparator_out,
  output logic external_clock_pin
);
  initial begin
    capture_input_pin = 1'b0;
    comparator_out = 1'b0;
    external_clock_pin = 1'b0;
  end
  // Level held three edges so the edge detector sees it
  task automatic set_cap(input logic src, input logic lvl);
    if (src) begin
      comparator_out <= lvl;
    end else begin
      capture_input_pin <= lvl;
    end
    repeat (3) @(posedge sys_clk);
  endtask
  // One rising and one falling edge per count
  task automatic ext_pulses(input int n);
    repeat (n) begin
      external_clock_pin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      external_clock_pin <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  tc16_pkg::tc16_io_req_t io_req = '0;
  logic [7:0] io_rdata;
  logic global_int_en = 1'b0;
  logic [3:0] vector_taken = 4'h0;
  logic [3:0] irq_req;
  logic cap_pin, cmp_out, ext_pin, wave_a, wave_b;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int seed = 59401;
  int dv [4] = '{8, 64, 256, 1024};
  logic [7:0] d8;
  logic [15:0] v, r;

  always #12.5 sys_clk = ~sys_clk;

  tc16_pin_model pins (.sys_clk(sys_clk), .capture_input_pin(cap_pin), .comparator_out(cmp_out),
    .external_clock_pin(ext_pin));
  tc16_timer dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .io_req(io_req), .io_rdata(io_rdata),
    .global_int_en(global_int_en), .vector_taken(vector_taken), .irq_req(irq_req),
    .capture_input_pin(cap_pin), .comparator_out(cmp_out), .external_clock_pin(ext_pin),
    .waveform_output_a(wave_a), .waveform_output_b(wave_b));

  task automatic complete_run();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole plan needs about 6000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, input int hi, input logic [15:0] s);
    samples_checked++;
    if ($isunknown(s) || s < lo || s > hi) begin
      fail_count++;
      $display("[FAIL] %s exp %0d..%0d got %h", n, lo, hi, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_req <= {1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    io_req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    io_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    io_req <= '0;
    #1 d = io_rdata;
    @(posedge sys_clk);
  endtask
  // High byte goes first on write, low byte first on read
  task automatic w16(input logic [7:0] a, input logic [15:0] x);
    wr(a + 8'h01, x[15:8]);
    wr(a, x[7:0]);
  endtask
  task automatic r16(input logic [7:0] a, output logic [15:0] x);
    logic [7:0] l, h;
    rd(a, l);
    rd(a + 8'h01, h);
    x = {h, l};
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    rd(a, d8);
    chk(n, {8'h00, e}, {8'h00, d8});
  endtask
  task automatic irqc(input string n, input logic [3:0] e);
    repeat (3) @(posedge sys_clk);
    #1 chk(n, {12'h000, e}, {12'h000, irq_req});
    @(posedge sys_clk);
  endtask
  task automatic run(input logic [7:0] cs, input int n);
    wr(tc16_pkg::A_CTRL_B, cs);
    repeat (n) @(posedge sys_clk);
    wr(tc16_pkg::A_CTRL_B, cs & 8'hf8);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rchk("mask_rst", tc16_pkg::A_MASK, 8'h00);
    rchk("flags_rst", tc16_pkg::A_FLAGS, 8'h00);
    rchk("unmapped", 8'h03, 8'h00);
    r16(tc16_pkg::A_CMPA_L, r);
    chk("cmpa_rst", 16'h0000, r);
    wr(tc16_pkg::A_CTRL_B, 8'h60);
    rchk("ctrlb_rsv", tc16_pkg::A_CTRL_B, 8'h40);
    wr(tc16_pkg::A_CTRL_B, 8'h00);
    wr(tc16_pkg::A_MASK, 8'hff);
    rchk("mask_bits", tc16_pkg::A_MASK, 8'h27);
    wr(tc16_pkg::A_FLAGS, 8'hff);
    rchk("flags_bits", tc16_pkg::A_FLAGS, 8'h00);
    wr(tc16_pkg::A_MASK, 8'h02);
    v = 16'($random(seed));
    w16(tc16_pkg::A_CNT_L, v);
    repeat (20) @(posedge sys_clk);
    r16(tc16_pkg::A_CNT_L, r);
    chk("cnt_stop", v, r);
    v = {2'b01, 14'($random(seed))};
    w16(tc16_pkg::A_CMPB_L, v);
    r16(tc16_pkg::A_CMPB_L, r);
    chk("cmpb", v, r);
    v = 16'($random(seed));
    w16(tc16_pkg::A_CAP_L, v);
    r16(tc16_pkg::A_CAP_L, r);
    chk("cap_rw", v, r);
    // Start on the match value: first tick after the counter write is blocked
    w16(tc16_pkg::A_CMPA_L, 16'h0040);
    for (int k = 0; k < 2; k++) begin
      wr(tc16_pkg::A_FLAGS, 8'hff);
      w16(tc16_pkg::A_CNT_L, k ? 16'h0030 : 16'h0040);
      run(8'h01, 40);
      rchk("flag_a", tc16_pkg::A_FLAGS, k ? 8'h02 : 8'h00);
    end
    global_int_en <= 1'b1;
    irqc("irq_on", 4'h2);
    global_int_en <= 1'b0;
    irqc("irq_off", 4'h0);
    wr(tc16_pkg::A_FLAGS, 8'h00);
    rchk("flag_keep", tc16_pkg::A_FLAGS, 8'h02);
    vector_taken <= 4'h2;
    @(posedge sys_clk);
    vector_taken <= 4'h0;
    @(posedge sys_clk);
    rchk("vec_clr", tc16_pkg::A_FLAGS, 8'h00);
    w16(tc16_pkg::A_CNT_L, 16'hfff0);
    run(8'h01, 30);
    rchk("ovf", tc16_pkg::A_FLAGS, 8'h01);
    wr(tc16_pkg::A_FLAGS, 8'h01);
    rchk("w1c", tc16_pkg::A_FLAGS, 8'h00);
    for (int k = 0; k < 4; k++) begin
      w16(tc16_pkg::A_CNT_L, 16'h0000);
      run(8'(k + 2), 4 * dv[k]);
      r16(tc16_pkg::A_CNT_L, r);
      chk_rng("prescale", 3, 5, r);
    end
    for (int k = 6; k < 8; k++) begin
      w16(tc16_pkg::A_CNT_L, 16'h0000);
      wr(tc16_pkg::A_CTRL_B, 8'(k));
      pins.ext_pulses(5);
      wr(tc16_pkg::A_CTRL_B, 8'h00);
      r16(tc16_pkg::A_CNT_L, r);
      chk("ext", 16'h0005, r);
    end
    for (int s = 0; s < 2; s++) begin
      for (int e = 0; e < 2; e++) begin
        wr(tc16_pkg::A_CTRL_A, 8'(s << 2));
        wr(tc16_pkg::A_CTRL_B, 8'(e << 6));
        pins.set_cap(s[0], e[0]);
        v = 16'($random(seed));
        w16(tc16_pkg::A_CNT_L, v);
        wr(tc16_pkg::A_FLAGS, 8'hff);
        pins.set_cap(s[0], !e[0]);
        rchk("cap_wrong", tc16_pkg::A_FLAGS, 8'h00);
        pins.set_cap(s[0], e[0]);
        rchk("cap_flag", tc16_pkg::A_FLAGS, 8'h20);
        r16(tc16_pkg::A_CAP_L, r);
        chk("cap_val", v, r);
      end
    end
    // Waveform mode 12: capture register is top
    wr(tc16_pkg::A_CTRL_A, 8'h00);
    wr(tc16_pkg::A_CTRL_B, 8'h58);
    pins.set_cap(1'b0, 1'b0);
    w16(tc16_pkg::A_CNT_L, 16'h0001);
    w16(tc16_pkg::A_CAP_L, 16'h0100);
    wr(tc16_pkg::A_FLAGS, 8'hff);
    pins.set_cap(1'b0, 1'b1);
    rchk("cap_top", tc16_pkg::A_FLAGS, 8'h00);
    r16(tc16_pkg::A_CAP_L, r);
    chk("cap_keep", 16'h0100, r);
    w16(tc16_pkg::A_CAP_L, 16'h0010);
    w16(tc16_pkg::A_CNT_L, 16'h0000);
    run(8'h59, 30);
    rchk("cap_at_top", tc16_pkg::A_FLAGS, 8'h20);
    wr(tc16_pkg::A_CTRL_B, 8'h00);
    wr(tc16_pkg::A_CTRL_A, 8'h50);
    wr(tc16_pkg::A_FLAGS, 8'hff);
    for (int k = 0; k < 2; k++) begin
      d8 = {6'h00, wave_b, wave_a};
      wr(tc16_pkg::A_CTRL_C, 8'hc0);
      repeat (2) @(posedge sys_clk);
      #1 chk("force", {14'h0000, ~d8[1:0]}, {14'h0000, wave_b, wave_a});
      @(posedge sys_clk);
    end
    // Set-on-match mode: a forced match drives both outputs high
    wr(tc16_pkg::A_CTRL_A, 8'hf0);
    wr(tc16_pkg::A_CTRL_C, 8'hc0);
    #1 chk("force_set", 16'h0003, {14'h0000, wave_b, wave_a});
    @(posedge sys_clk);
    rchk("force_flag", tc16_pkg::A_FLAGS, 8'h00);
    rchk("force_rd", tc16_pkg::A_CTRL_C, 8'h00);
    w16(tc16_pkg::A_CNT_L, 16'h0123);
    wr(tc16_pkg::A_CTRL_B, 8'h08);
    wr(tc16_pkg::A_CTRL_C, 8'h80);
    r16(tc16_pkg::A_CNT_L, r);
    chk("force_cnt", 16'h0123, r);
    wr(tc16_pkg::A_CTRL_A, 8'h51);
    wr(tc16_pkg::A_CTRL_C, 8'h00);
    // Phase-correct 8-bit: turns at top, overflows at bottom
    wr(tc16_pkg::A_CTRL_A, 8'h01);
    wr(tc16_pkg::A_CTRL_B, 8'h00);
    w16(tc16_pkg::A_CNT_L, 16'h00fc);
    wr(tc16_pkg::A_FLAGS, 8'hff);
    run(8'h01, 10);
    rchk("phase_top", tc16_pkg::A_FLAGS, 8'h00);
    r16(tc16_pkg::A_CNT_L, r);
    chk_rng("phase_down", 16'h00f4, 16'h00f8, r);
    w16(tc16_pkg::A_CNT_L, 16'h0004);
    run(8'h01, 10);
    rchk("phase_bottom", tc16_pkg::A_FLAGS, 8'h01);
    r16(tc16_pkg::A_CNT_L, r);
    chk_rng("phase_up", 6, 10, r);
    complete_run();
  end
endmodule
`default_nettype wire
